// ==== ilog_checker.sv ====
// Port-level assertions for the interrupt log block
`timescale 1ns/1ns
module ilog_checker (
   input wire        clk,
   input wire        rst,
   input wire [15:0] reg_addr,
   input wire        reg_rd,
   input wire        reg_wr,
   input wire [15:0] reg_rdata,
   input wire [15:0] hw_event,
   input wire [15:0] bc_event,
   input wire [15:0] mt_event,
   input wire [15:0] rt_event,
   input wire        ram_ack,
   input wire        ram_we,
   input wire [15:0] ram_addr,
   input wire [15:0] ram_wdata,
   input wire        edc_mode,
   input wire        irq_n
);
   logic [15:0] last_r;
   wire  [15:0] next_w = (last_r == 16'h01bf) ? 16'h0180 : last_r + 16'h0001;
   wire         ev_w = |{hw_event, bc_event, mt_event, rt_event};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Odd address of the last finished record
   always @(posedge clk or posedge rst)
      if (rst) last_r <= 16'h01bf;
      else if (ram_we && ram_ack && ram_addr[0]) last_r <= ram_addr;
   sequence s_id_done; ram_we && ram_ack && !ram_addr[0]; endsequence
   sequence s_aw_next; ram_we && ram_addr == $past(ram_addr) + 16'h0001; endsequence
   property p_range; ram_we |-> ram_addr >= 16'h0180 && ram_addr <= 16'h01bf; endproperty
   property p_pair; s_id_done |=> s_aw_next; endproperty
   property p_wrap; $rose(ram_we) |-> ram_addr == next_w; endproperty
   property p_hold;
      ram_we && !ram_ack |=> ram_we && $stable(ram_addr) && $stable(ram_wdata);
   endproperty
   property p_edc; !$past(rst) && !$past(rst, 2) |-> $stable(edc_mode); endproperty
   property p_irq;
      $fell(irq_n) |-> $past(ev_w, 2) || $past(ev_w, 3) || $past(reg_wr, 2);
   endproperty
   property p_ptr; reg_rd && reg_addr == 16'h000a |-> ##2 reg_rdata[8:6] == 3'h6; endproperty
   property p_ro; reg_rd && reg_addr == 16'h000f |-> ##2 reg_rdata[4:0] == 5'h00; endproperty
   property p_unmap; reg_rd && reg_addr == 16'h0002 |-> ##2 reg_rdata == 16'h0000; endproperty
   a_range: assert property (p_range) else $error("log write outside buffer");
   a_pair: assert property (p_pair) else $error("address word not at odd slot");
   a_wrap: assert property (p_wrap) else $error("record start not after last");
   a_hold: assert property (p_hold) else $error("ram request changed early");
   a_edc: assert property (p_edc) else $error("edc mode changed in run");
   a_irq: assert property (p_irq) else $error("irq without cause");
   a_ptr: assert property (p_ptr) else $error("pointer outside log");
   a_ro: assert property (p_ro) else $error("enable low bits not zero");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// ==== ilog_ptr.v ====
// Log write pointer and saturating event counter
`timescale 1ns/1ns
module ilog_ptr #(
   parameter CNT_W = 7
) (
   clk,
   rst,
   advance,
   count_clear,
   ptr,
   count
);
   input  wire             clk;
   input  wire             rst;
   input  wire             advance;
   input  wire             count_clear;
   output reg  [4:0]       ptr;
   output reg  [CNT_W-1:0] count;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr   <= 5'h00;
         count <= {CNT_W{1'b0}};
      end else begin
         if (advance)
            ptr <= ptr + 5'h01;
         if (count_clear)
            count <= advance ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
         else if (advance && count != {CNT_W{1'b1}})
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// ==== ilog_ram_model.sv ====
// RAM model behind the log writer, with adjustable acknowledge delay
`timescale 1ns/1ns
module ilog_ram_model (
   input  wire        clk,
   input  wire        rst,
   input  wire [1:0]  lat,
   input  wire        ram_we,
   input  wire [15:0] ram_addr,
   input  wire [15:0] ram_wdata,
   output logic       ram_ack
);
   logic [15:0] mem [0:63];
   logic [1:0]  cnt_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ram_ack <= 1'b0;
         cnt_r   <= 2'h0;
      end else if (ram_we && ram_ack) begin
         mem[ram_addr[5:0]] <= ram_wdata;
         ram_ack <= 1'b0;
         cnt_r   <= 2'h0;
      end else if (ram_we && cnt_r >= lat) begin
         ram_ack <= 1'b1;
      end else if (ram_we) begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
endmodule

// ==== ilog_regs.vh ====
// Register offsets, field positions, reset values for interrupt log block
`ifndef ILOG_REGS_VH
`define ILOG_REGS_VH
`define ILOG_OFS_HW_PEND     16'h0006
`define ILOG_OFS_LOG_PTR     16'h000a
`define ILOG_OFS_HW_EN       16'h000f
`define ILOG_OFS_HW_OE       16'h0013
`define ILOG_LOG_BASE        16'h0180
`define ILOG_LOG_LAST        16'h01bf
`define ILOG_HW_ADDR_WORD    16'h0000
`define ILOG_RO_EN_MASK      16'h001f
`define ILOG_BIT_FRAMING     15
`define ILOG_BIT_CKSUM       14
`define ILOG_BIT_UNCORR      13
`define ILOG_BIT_RT_PEND     2
`define ILOG_BIT_MT_PEND     1
`define ILOG_BIT_BC_PEND     0
`define ILOG_MSR_BIT_CKSUM   1
`define ILOG_MSR_BIT_LOAD    0
`define ILOG_BIT_LOAD_EVT    4
`define ILOG_EN_RESET        16'h0000
`define ILOG_CNT_MAX         7'h7f
`endif

// ==== ilog_top.v ====
// Interrupt log writer and hardware interrupt register triplet
`timescale 1ns/1ns
`include "ilog_regs.vh"
module ilog_top #(
   parameter DW = 16
) (
   clk,
   rst,
   edc_select_pin,
   auto_load_pin,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   hw_event,
   bc_event,
   bc_addr,
   mt_event,
   mt_addr,
   mt_packet_mode,
   rt_event,
   rt_addr,
   rt_pend_nonzero,
   mt_pend_nonzero,
   bc_pend_nonzero,
   ram_ack,
   ram_we,
   ram_addr,
   ram_wdata,
   edc_mode,
   rom_checksum_fail_flag,
   ram_load_mismatch_flag,
   irq_n
);
   input  wire          clk;
   input  wire          rst;
   input  wire          edc_select_pin;
   input  wire          auto_load_pin;
   input  wire [15:0]   reg_addr;
   input  wire [DW-1:0] reg_wdata;
   input  wire          reg_wr;
   input  wire          reg_rd;
   output reg  [DW-1:0] reg_rdata;
   input  wire [DW-1:0] hw_event;
   input  wire [DW-1:0] bc_event;
   input  wire [15:0]   bc_addr;
   input  wire [DW-1:0] mt_event;
   input  wire [15:0]   mt_addr;
   input  wire          mt_packet_mode;
   input  wire [DW-1:0] rt_event;
   input  wire [15:0]   rt_addr;
   input  wire          rt_pend_nonzero;
   input  wire          mt_pend_nonzero;
   input  wire          bc_pend_nonzero;
   input  wire          ram_ack;
   output reg           ram_we;
   output reg  [15:0]   ram_addr;
   output reg  [15:0]   ram_wdata;
   output reg           edc_mode;
   output reg           rom_checksum_fail_flag;
   output reg           ram_load_mismatch_flag;
   output reg           irq_n;

   // ------------------------------------------------------------
   // Writer states
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE  = 3'b001;
   localparam [2:0] S_IDENT = 3'b010;
   localparam [2:0] S_ADDR  = 3'b100;

   localparam [1:0] SRC_HW = 2'd0;
   localparam [1:0] SRC_BC = 2'd1;
   localparam [1:0] SRC_MT = 2'd2;
   localparam [1:0] SRC_RT = 2'd3;

   // Register triplet and strap state
   reg  [DW-1:0] hw_en_r;
   reg  [DW-1:0] hw_oe_r;
   reg  [DW-1:0] hw_pend_r;
   reg           cksum_valid_r;
   reg           strap_done_r;
   // Per-source record slots (hardware, bc, mt, rt)
   reg  [3:0]    job_r;
   reg  [DW-1:0] id_r     [0:3];
   reg  [15:0]   aw_r     [0:3];
   // Log writer
   reg  [2:0]    state_r;
   reg  [15:0]   aw_hold_r;
   wire [4:0]    ptr;
   wire [6:0]    count;
   wire          advance;
   wire          take;
   // Register access and interrupt helpers
   wire          ptr_read;
   wire          pend_read;
   wire [DW-1:0] hw_live;
   wire [15:0]   log_ptr_word;
   reg  [DW-1:0] hw_evt_gated;
   reg  [1:0]    pick;
   reg  [DW-1:0] rdata_nxt;
   wire          irq_hw;
   wire          irq_term;

   assign ptr_read  = reg_rd && (reg_addr == `ILOG_OFS_LOG_PTR);
   assign pend_read = reg_rd && (reg_addr == `ILOG_OFS_HW_PEND);
   assign advance   = (state_r == S_ADDR) && ram_ack;
   // Writer claims a slot in the cycle it starts the ident word
   assign take      = (state_r == S_IDLE) && (|job_r);
   assign log_ptr_word = {count, 3'b110, ptr, 1'b0};
   // One shared request line: hardware bits 15:5 (bits 4:3 left out), plus summaries
   assign irq_hw    = |(hw_pend_r & hw_oe_r & ~`ILOG_RO_EN_MASK);
   assign irq_term  = |(hw_pend_r[2:0] & hw_oe_r[2:0]);

   // ------------------------------------------------------------
   // Strap capture at reset release
   // ------------------------------------------------------------
   // Straps are read once, on the first edge after reset release
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_done_r  <= 1'b0;
         cksum_valid_r <= 1'b0;
         edc_mode      <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r  <= 1'b1;
         cksum_valid_r <= !edc_select_pin && auto_load_pin;
         edc_mode      <= edc_select_pin;
      end
   end

   // ------------------------------------------------------------
   // Event gating
   // ------------------------------------------------------------
   // Checksum bit kept under the auto-load strap or in edc mode; bit 13 only in edc mode
   always @* begin
      hw_evt_gated = hw_event & hw_en_r;
      if (!cksum_valid_r && !edc_mode)
         hw_evt_gated[`ILOG_BIT_CKSUM] = 1'b0;
      if (!edc_mode)
         hw_evt_gated[`ILOG_BIT_UNCORR] = 1'b0;
      hw_evt_gated[2:0] = 3'b000;
   end

   assign hw_live = hw_evt_gated |
                    {{(DW-3){1'b0}}, rt_pend_nonzero, mt_pend_nonzero, bc_pend_nonzero};

   // ------------------------------------------------------------
   // Hardware register triplet
   // ------------------------------------------------------------
   // Low enable bits keep their reset value
   always @(posedge clk or posedge rst) begin
      if (rst)
         hw_en_r <= `ILOG_EN_RESET | ({{(DW-1){1'b0}}, 1'b1} << `ILOG_BIT_CKSUM);
      else if (reg_wr && reg_addr == `ILOG_OFS_HW_EN)
         hw_en_r <= (reg_wdata & ~`ILOG_RO_EN_MASK) |
                    (hw_en_r & `ILOG_RO_EN_MASK);
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         hw_oe_r <= `ILOG_EN_RESET | ({{(DW-1){1'b0}}, 1'b1} << `ILOG_BIT_CKSUM);
      else if (reg_wr && reg_addr == `ILOG_OFS_HW_OE)
         hw_oe_r <= reg_wdata;
   end

   // Set wins over read-clear
   always @(posedge clk or posedge rst) begin
      if (rst)
         hw_pend_r <= {DW{1'b0}};
      else
         hw_pend_r <= (pend_read ? {DW{1'b0}} : hw_pend_r) | hw_live;
   end

   // ------------------------------------------------------------
   // Master status flags
   // ------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rom_checksum_fail_flag <= 1'b0;
         ram_load_mismatch_flag <= 1'b0;
      end else begin
         if (hw_evt_gated[`ILOG_BIT_CKSUM] && !edc_mode)
            rom_checksum_fail_flag <= 1'b1;
         // Load mismatch only counts under the auto-load strap
         if (hw_evt_gated[`ILOG_BIT_UNCORR])
            ram_load_mismatch_flag <= 1'b0;
         else if (hw_event[`ILOG_BIT_LOAD_EVT] && cksum_valid_r)
            ram_load_mismatch_flag <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Record queue, one slot per source (hardware, bc, mt, rt)
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_src
         localparam [1:0] SLOT = g;
         wire [DW-1:0] ev;
         wire [15:0]   aw;
         assign ev = (g == 0) ? hw_evt_gated :
                     (g == 1) ? bc_event : (g == 2) ? mt_event : rt_event;
         assign aw = (g == 0) ? `ILOG_HW_ADDR_WORD :
                     (g == 1) ? bc_addr :
                     (g == 2) ? mt_addr :
                     rt_addr;
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               job_r[g] <= 1'b0;
               id_r[g]  <= {DW{1'b0}};
               aw_r[g]  <= 16'h0000;
            end else if (|ev) begin
               // Merge only into a record the writer has not started yet
               job_r[g] <= 1'b1;
               id_r[g]  <= (job_r[g] && !(take && pick == SLOT)) ? (id_r[g] | ev) : ev;
               aw_r[g]  <= aw;
            end else if (take && pick == SLOT) begin
               job_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Writer source pick
   // ------------------------------------------------------------
   always @* begin
      pick = SRC_HW;
      if (job_r[0])
         pick = SRC_HW;
      else if (job_r[1])
         pick = SRC_BC;
      else if (job_r[2])
         pick = SRC_MT;
      else if (job_r[3])
         pick = SRC_RT;
   end

   // ------------------------------------------------------------
   // Log writer
   // ------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r   <= S_IDLE;
         aw_hold_r <= 16'h0000;
         ram_we    <= 1'b0;
         ram_addr  <= `ILOG_LOG_BASE;
         ram_wdata <= 16'h0000;
      end else begin
         case (state_r)
            S_IDLE: begin
               ram_we <= 1'b0;
               if (|job_r) begin
                  aw_hold_r <= aw_r[pick];
                  ram_we    <= 1'b1;
                  ram_addr  <= `ILOG_LOG_BASE | {10'h000, ptr, 1'b0};
                  ram_wdata <= id_r[pick];
                  state_r   <= S_IDENT;
               end
            end
            S_IDENT: begin
               if (ram_ack) begin
                  ram_addr  <= `ILOG_LOG_BASE | {10'h000, ptr, 1'b1};
                  ram_wdata <= aw_hold_r;
                  state_r   <= S_ADDR;
               end
            end
            // Pointer moves only once the address word is accepted
            S_ADDR: begin
               if (ram_ack) begin
                  ram_we  <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
               ram_we  <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pointer and event count
   // ------------------------------------------------------------
   ilog_ptr #(
      .CNT_W (7)
   ) u_ptr (
      .clk         (clk),
      .rst         (rst),
      .advance     (advance),
      .count_clear (ptr_read),
      .ptr         (ptr),
      .count       (count)
   );

   // ------------------------------------------------------------
   // Read data and interrupt output
   // ------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `ILOG_OFS_HW_PEND: rdata_nxt = hw_pend_r;
         `ILOG_OFS_HW_EN:   rdata_nxt = hw_en_r;
         `ILOG_OFS_HW_OE:   rdata_nxt = hw_oe_r;
         `ILOG_OFS_LOG_PTR: rdata_nxt = log_ptr_word;
         default:           rdata_nxt = {DW{1'b0}};
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= {DW{1'b0}};
         irq_n     <= 1'b1;
      end else begin
         if (reg_rd)
            reg_rdata <= rdata_nxt;
         irq_n <= ~(irq_hw | irq_term);
      end
   end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the interrupt log block
`timescale 1ns/1ns
module tb_top;
   logic        clk = 0, rst = 1, edc_select_pin = 0, auto_load_pin = 1, reg_wr = 0, reg_rd = 0;
   logic        mt_packet_mode = 0, rt_pend_nonzero = 0, mt_pend_nonzero = 0, bc_pend_nonzero = 0;
   logic [15:0] reg_addr = 0, reg_wdata = 0, hw_event = 0, bc_event = 0, mt_event = 0;
   logic [15:0] rt_event = 0, bc_addr = 0, mt_addr = 0, rt_addr = 0, v, x, pend = 0;
   logic [1:0]  lat = 0;
   wire         ram_ack, ram_we, edc_mode, rom_checksum_fail_flag, ram_load_mismatch_flag, irq_n;
   wire  [15:0] reg_rdata, ram_addr, ram_wdata;
   integer      num_errors = 0, total_checks = 0, seed = 42, wp = 0, cnt = 0, k;
   logic [15:0] exp_mem [0:63];
   always #5 clk = ~clk;
   ilog_top dut (.*);
   ilog_ram_model u_ram (.*);
   task chk(input string n, input logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task wreg(input [15:0] a, d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rchk(input string n, input [15:0] a, e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1 chk(n, e, reg_rdata);
   endtask
   function void logrec(input [15:0] id, aw);
      exp_mem[wp*2] = id;
      exp_mem[wp*2+1] = aw;
      wp = (wp + 1) % 32;
      cnt = (cnt < 127) ? cnt + 1 : 127;
   endfunction
   function [15:0] ptrv;
      ptrv = {cnt[6:0], 3'h6, wp[4:0], 1'b0};
   endfunction
   task ev(input [15:0] eh, eb, em, er, xb, xm, xr, ih);
      integer q, t;
      @(posedge clk);
      x = $random(seed);
      hw_event <= eh;
      bc_event <= eb;
      mt_event <= em;
      rt_event <= er;
      bc_addr <= xb;
      mt_addr <= xm;
      rt_addr <= xr;
      lat <= x[5:4];
      mt_packet_mode <= x[6];
      @(posedge clk);
      {hw_event, bc_event, mt_event, rt_event} <= 64'h0;
      if (ih) logrec(ih, 16'h0000);
      if (eb) logrec(eb, xb);
      if (em) logrec(em, xm);
      if (er) logrec(er, xr);
      pend |= ih;
      q = 0;
      for (t = 0; t < 300 && q < 6; t++) begin
         @(posedge clk);
         q = ram_we ? 0 : q + 1;
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rchk("enable", 16'h000f, 16'h4000);
      rchk("out_enable", 16'h0013, 16'h4000);
      rchk("log_ptr", 16'h000a, 16'h0180);
      rchk("unmapped", 16'h0002, 16'h0000);
      ev(16'h8020, 0, 0, 0, 0, 0, 0, 0);
      rchk("pend_off", 16'h0006, 16'h0000);
      wreg(16'h000f, 16'hffff);
      rchk("enable_ro", 16'h000f, 16'hffe0);
      wreg(16'h0013, 16'h8000);
      $display("test reset_regs done");
      ev(16'h6020, 16'h0011, 16'h0003, 16'h0300, 16'h1234, 16'h0456, 16'h0789, 16'h4020);
      chk("cksum_flag", 16'h0001, {15'h0, rom_checksum_fail_flag});
      chk("irq_low_prio", 16'h0001, {15'h0, irq_n});
      ev(16'h8000, 16'h0005, 0, 0, 16'h0abc, 0, 0, 16'h8000);
      chk("irq", 16'h0000, {15'h0, irq_n});
      rchk("pend", 16'h0006, pend);
      pend = 0;
      repeat (2) @(posedge clk);
      #1 chk("irq_off", 16'h0001, {15'h0, irq_n});
      @(posedge clk);
      {rt_pend_nonzero, mt_pend_nonzero, bc_pend_nonzero} <= 3'b101;
      rchk("pend_mirror", 16'h0006, 16'h0005);
      @(posedge clk);
      {rt_pend_nonzero, mt_pend_nonzero, bc_pend_nonzero} <= 3'b000;
      rchk("pend_held", 16'h0006, 16'h0005);
      rchk("pend_clr", 16'h0006, 16'h0000);
      rchk("log_ptr", 16'h000a, ptrv());
      cnt = 0;
      ev(16'h0010, 0, 0, 0, 0, 0, 0, 0);
      chk("load_flag_set", 16'h0001, {15'h0, ram_load_mismatch_flag});
      $display("test corners done");
      for (k = 0; k < 140; k++) begin
         x = $random(seed);
         v = $random(seed) & 16'hdfe0 & {16{x[0]}};
         ev(v, $random(seed) & {16{x[1]}}, $random(seed) & {16{x[2]}},
            $random(seed) & {16{x[3]}}, $random(seed), $random(seed), $random(seed), v);
      end
      rchk("log_ptr_sat", 16'h000a, ptrv());
      cnt = 0;
      rchk("log_ptr_clr", 16'h000a, ptrv());
      for (k = 0; k < 64; k++) chk("log_word", exp_mem[k], u_ram.mem[k]);
      rchk("pend_rand", 16'h0006, pend);
      $display("test random done");
      @(posedge clk);
      rst <= 1'b1;
      edc_select_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("edc_mode", 16'h0001, {15'h0, edc_mode});
      wp = 0;
      cnt = 0;
      wreg(16'h000f, 16'h2000);
      ev(16'h2000, 0, 0, 0, 0, 0, 0, 16'h2000);
      rchk("pend_uncorr", 16'h0006, 16'h2000);
      chk("load_flag", 16'h0000, {15'h0, ram_load_mismatch_flag});
      chk("hw_addr_word", 16'h0000, u_ram.mem[1]);
      rchk("log_ptr_edc", 16'h000a, ptrv());
      $display("test edc done");
      print_verdict;
   end
endmodule
bind ilog_top ilog_checker u_chk (.*);
